// [logic/icx_map.svh]
// Constants for the idle / normalize / invert / OR execution block.
// Assumes inclusion by the package and the execution modules.
`ifndef ICX_MAP_SVH
`define ICX_MAP_SVH
`define ICX_W 32
`define ICX_LW 40
`define ICX_CNT_W 4
`define ICX_IDLE_MAX 4'h8
`define ICX_IDLE_NONE 4'h0
`define ICX_CST_W 5
`define ICX_OPL_W 7
`define ICX_OPS_W 6
`define ICX_L_OR_REG 7'h7f
`define ICX_L_OR_CST 7'h7e
`define ICX_L_NORM_INT 7'h63
`define ICX_L_NORM_LONG 7'h60
`define ICX_S_OR_REG 6'h1b
`define ICX_S_OR_CST 6'h1a
`define ICX_NCNT_W 6
`endif

// [logic/icx_pkg.sv]
// Types shared by the execution block.
// Assumes icx_map.svh is on the include path.
`include "icx_map.svh"
package icx_pkg;
    typedef enum logic [1:0] {
        ICX_UNIT_L = 2'h1,
        ICX_UNIT_S = 2'h2
    } icx_unit_t;

    typedef enum logic [3:0] {
        ICX_OP_OR = 4'h1,
        ICX_OP_NOT = 4'h2,
        ICX_OP_NORM = 4'h4,
        ICX_OP_NONE = 4'h8
    } icx_op_t;

    typedef struct packed {
        logic valid;
        icx_unit_t unit;
        logic [`ICX_OPL_W-1:0] opfield;
        logic [`ICX_W-1:0] src1;
        logic [`ICX_CST_W-1:0] signed_five_bit_constant;
        logic [`ICX_LW-1:0] src2;
        logic [4:0] dst;
    } icx_issue_t;

    typedef struct packed {
        logic valid;
        logic [4:0] dst;
        logic [`ICX_LW-1:0] data;
    } icx_result_t;

    typedef struct packed {
        logic valid;
        logic alone;
        logic [`ICX_CNT_W-1:0] count;
    } icx_idle_t;
endpackage

// [logic/icx_norm.sv]
// Redundant sign bit counter for 32-bit and 40-bit sources.
// Assumes combinational use within a single execute stage.
`timescale 1ns/10ps
`include "icx_map.svh"
module icx_norm
    import icx_pkg::*;
(
    input wire logic [`ICX_LW-1:0] src,
    input wire logic is_long,
    output logic [`ICX_NCNT_W-1:0] cnt
);
    // Bits below the sign that equal it, scanning downward
    function automatic logic [`ICX_NCNT_W-1:0] sign_run(
        input logic [`ICX_LW-1:0] v, input logic lng);
        logic [`ICX_NCNT_W-1:0] n;
        logic stop;
        int top;
        n = '0;
        stop = 1'b0;
        top = lng ? `ICX_LW - 1 : `ICX_W - 1;
        for (int i = `ICX_LW - 2; i >= 0; i--) begin
            if (i < top && !stop) begin
                if (v[i] == v[top]) begin
                    n = n + 6'h01;
                end else begin
                    stop = 1'b1;
                end
            end
        end
        return n;
    endfunction

    assign cnt = sign_run(src, is_long);
endmodule

// [logic/icx_exec.sv]
// Execution of idle, normalize, invert and OR in the .L/.S datapath.
// Assumes dispatch presents one decoded issue per cycle and a branch
// completion pulse; results are registered one cycle after issue.
`timescale 1ns/10ps
`include "icx_map.svh"
// Summary of operation
// RQ1: Idle holds the pipeline for count field plus one cycles.
// RQ2: Idle length at most nine; dispatcher encodes length minus one.
// RQ3: Idle without operand encodes zero count, acting as one-cycle idle.
// RQ4: Multicycle idle ends early once a pending branch completes.
// RQ5: One-cycle idle beside other instructions changes nothing.
// RQ6: Normalize writes count of bits below sign equal to sign, one cycle.
// RQ7: Invert writes the bitwise complement of the 32-bit source.
// RQ8: OR writes bitwise OR of two words, on .L and .S, one cycle.
// RQ9: Five-bit constant form sign-extends to a full word before OR.
// RQ10: Opfield picks register or constant OR form per unit.
// RQ11: Long normalize counts redundant sign bits across all forty bits.
module icx_exec
    import icx_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire icx_issue_t issue,
    input wire icx_idle_t idle_req,
    input wire logic branch_done,
    output icx_result_t result,
    output logic stall,
    output logic idle_err
);
    typedef enum logic [1:0] {
        ICX_ST_RUN = 2'h1,
        ICX_ST_IDLE = 2'h2
    } icx_state_t;

    icx_state_t state_r, state_nxt;
    logic [`ICX_CNT_W-1:0] left_r, left_nxt;
    icx_result_t result_r, result_nxt;
    logic err_r;

    function automatic logic [`ICX_W-1:0] sext5(input logic [`ICX_CST_W-1:0] c);
        return {{(`ICX_W-`ICX_CST_W){c[`ICX_CST_W-1]}}, c};
    endfunction

    function automatic logic [`ICX_LW-1:0] zext32(input logic [`ICX_W-1:0] v);
        return {{(`ICX_LW-`ICX_W){1'b0}}, v};
    endfunction

    // Opfield decode, per unit
    wire is_l = issue.unit == ICX_UNIT_L;
    wire is_s = issue.unit == ICX_UNIT_S;
    wire [`ICX_OPS_W-1:0] op_s = issue.opfield[`ICX_OPS_W-1:0];
    wire or_reg = (is_l && issue.opfield == `ICX_L_OR_REG)
        || (is_s && op_s == `ICX_S_OR_REG); // [RQ10]
    wire or_cst = (is_l && issue.opfield == `ICX_L_OR_CST)
        || (is_s && op_s == `ICX_S_OR_CST); // [RQ10]
    wire norm_int = is_l && issue.opfield == `ICX_L_NORM_INT;
    wire norm_long = is_l && issue.opfield == `ICX_L_NORM_LONG;
    // Invert is issued as XOR with all ones; any other code of ours maps here
    wire do_not = !or_reg && !or_cst && !norm_int && !norm_long;

    wire [`ICX_W-1:0] src2_w = issue.src2[`ICX_W-1:0];
    wire [`ICX_W-1:0] or_a = or_cst ? sext5(issue.signed_five_bit_constant)
        : issue.src1; // [RQ9]
    wire [`ICX_W-1:0] or_val = or_a | src2_w; // [RQ8]
    wire [`ICX_W-1:0] not_val = src2_w ^ {`ICX_W{1'b1}}; // [RQ7]
    wire [`ICX_NCNT_W-1:0] norm_cnt;
    wire [`ICX_LW-1:0] norm_src = norm_long ? issue.src2 : zext32(src2_w);

    icx_norm u_norm (
        .src(norm_src),
        .is_long(norm_long), // [RQ11]
        .cnt(norm_cnt)
    );

    wire [`ICX_LW-1:0] op_val = (or_reg || or_cst) ? zext32(or_val)
        : (do_not ? zext32(not_val)
        : {{(`ICX_LW-`ICX_NCNT_W){1'b0}}, norm_cnt}); // [RQ6]

    // A lone idle with zero count costs one cycle; beside others it is inert
    wire idle_multi = idle_req.valid && idle_req.count != `ICX_IDLE_NONE; // [RQ3]
    wire idle_cap = idle_req.count > `ICX_IDLE_MAX; // [RQ2]
    wire [`ICX_CNT_W-1:0] idle_cnt = idle_cap ? `ICX_IDLE_MAX : idle_req.count;
    wire run = state_r == ICX_ST_RUN;

    // Idle: issued cycle plus count more cycles
    always_comb begin
        state_nxt = state_r;
        left_nxt = left_r;
        case (state_r)
            ICX_ST_RUN: begin
                if (idle_multi && !branch_done) begin
                    state_nxt = ICX_ST_IDLE; // [RQ1]
                    left_nxt = idle_cnt;
                end
            end
            ICX_ST_IDLE: begin
                if (branch_done || left_r == 4'h1) begin
                    state_nxt = ICX_ST_RUN; // [RQ4]
                    left_nxt = '0;
                end else begin
                    left_nxt = left_r - 4'h1;
                end
            end
            default: begin
                state_nxt = ICX_ST_RUN;
                left_nxt = '0;
            end
        endcase
    end

    always_comb begin
        result_nxt = '0;
        // Idle cycles suppress issue; companions of a zero-count idle still run
        if (run && issue.valid) begin // [RQ5]
            result_nxt.valid = 1'b1;
            result_nxt.dst = issue.dst;
            result_nxt.data = op_val;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= ICX_ST_RUN;
            left_r <= '0;
            result_r <= '0;
            err_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            left_r <= left_nxt;
            result_r <= result_nxt;
            err_r <= run && idle_req.valid && idle_cap;
        end
    end

    assign result = result_r;
    // Stall decodes the registered state, so it rises the cycle after the idle issues
    assign stall = !run;
    assign idle_err = err_r;

    idle_len_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ1]
        run && idle_req.valid && !branch_done && idle_req.count == 4'h3
        |=> stall [*3] ##1 !stall)
        else $error("idle length wrong");

    sequence idle_start_s;
        run && idle_multi && !branch_done;
    endsequence

    sequence branch_end_s;
        stall && branch_done;
    endsequence

    idle_break_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ4]
        branch_end_s |=> !stall)
        else $error("branch did not end idle");

    idle_max_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ2]
        idle_start_s |=> ##[0:8] !stall)
        else $error("idle beyond nine cycles");

    idle_zero_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ3]
        run && idle_req.valid && idle_req.count == `ICX_IDLE_NONE |=> !stall)
        else $error("zero idle stalled");

    idle_inert_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ5]
        run && issue.valid && !idle_multi |=> result.valid && !stall)
        else $error("single idle disturbed issue");

    norm_count_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ6]
        run && issue.valid && norm_int && src2_w == 32'h02a3469f
        |=> result.data == 40'h0000000005)
        else $error("normalize count wrong");

    invert_val_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ7]
        run && issue.valid && do_not
        |=> result.data[`ICX_W-1:0] == ~$past(src2_w))
        else $error("invert wrong");

    or_reg_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ8]
        run && issue.valid && or_reg
        |=> result.data[`ICX_W-1:0] == ($past(issue.src1) | $past(src2_w)))
        else $error("or result wrong");

    or_cst_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ9]
        run && issue.valid && or_cst && issue.signed_five_bit_constant[`ICX_CST_W-1]
        |=> result.data[`ICX_W-1:`ICX_CST_W] == {(`ICX_W-`ICX_CST_W){1'b1}})
        else $error("constant not sign extended");

    or_sel_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ10]
        run && issue.valid && is_s && op_s == `ICX_S_OR_CST
        |=> result.data[`ICX_CST_W-1:0]
        == ($past(issue.signed_five_bit_constant) | $past(src2_w[`ICX_CST_W-1:0])))
        else $error("opfield select wrong");

    norm_long_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ11]
        run && issue.valid && norm_long && issue.src2 == 40'h0000000001
        |=> result.data == 40'h0000000026)
        else $error("long normalize wrong");

    long_neg_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ11]
        run && issue.valid && norm_long && issue.src2 == 40'hffffffffff
        |=> result.data == 40'h0000000027)
        else $error("long negative normalize wrong");

    norm_neg_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ6]
        run && issue.valid && norm_int && src2_w == 32'hfffff25a
        |=> result.data == 40'h0000000013)
        else $error("negative normalize wrong");

    result_dst_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ8]
        run && issue.valid |=> result.valid && result.dst == $past(issue.dst))
        else $error("result destination wrong");

    // An issue held through the stall must not leak a result early
    idle_block_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ1]
        stall |=> !result.valid)
        else $error("result during idle");

    idle_err_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ2]
        run && idle_req.valid && idle_cap |=> idle_err)
        else $error("overlong idle not flagged");

    sequence nine_idle_s;
        stall [*8] ##1 !stall;
    endsequence

    // Longest idle, and any clamped request, lasts nine cycles in all
    idle_cap_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ2]
        run && idle_req.valid && !branch_done && idle_req.count >= `ICX_IDLE_MAX
        |=> nine_idle_s)
        else $error("longest idle wrong");
endmodule

// [sim/icx_disp_model.sv]
// Dispatch model: issues ops, idles and branch completions.
// Assumes callers enter its tasks just after a falling sys_clk edge.
`timescale 1ns/10ps
module icx_disp_model
    import icx_pkg::*;
(
    input wire logic sys_clk,
    output icx_issue_t issue,
    output icx_idle_t idle_req,
    output logic branch_done
);
    initial begin
        issue = '0;
        idle_req = '0;
        branch_done = 1'b0;
    end
    // Op stays valid after return, as a stalled dispatcher must hold it
    task automatic op(input icx_unit_t u, input logic [6:0] f, input logic [31:0] a,
        input logic [4:0] k, input logic [39:0] b, input logic z);
        issue = '{1'b1, u, f, a, k, b, 5'h03};
        idle_req = '{z, 1'b0, 4'h0};
        @(negedge sys_clk);
    endtask
    // Length goes out as length minus one
    task automatic idle(input int len);
        issue.valid = 1'b0;
        idle_req = '{1'b1, 1'b0, 4'(len - 1)};
        @(negedge sys_clk);
    endtask
    task automatic quiet();
        issue.valid = 1'b0;
        idle_req.valid = 1'b0;
    endtask
    task automatic brk(input logic v);
        branch_done = v;
    endtask
endmodule

// [sim/test_idle_count_or_invert_exec.sv]
// Bench for the idle / normalize / invert / OR execution block.
// Assumes icx_exec with the dispatch model driving its inputs.
`timescale 1ns/10ps
module test_idle_count_or_invert_exec
    import icx_pkg::*;
;
    logic sys_clk;
    logic rst;
    icx_issue_t issue;
    icx_idle_t idle_req;
    logic branch_done;
    icx_result_t result;
    logic stall;
    logic idle_err;
    int error_cnt = 0;
    int n_checks = 0;

    icx_exec dut (.sys_clk(sys_clk), .rst(rst), .issue(issue), .idle_req(idle_req),
        .branch_done(branch_done), .result(result), .stall(stall), .idle_err(idle_err));
    icx_disp_model disp (.sys_clk(sys_clk), .issue(issue), .idle_req(idle_req),
        .branch_done(branch_done));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic t_or();
        disp.op(ICX_UNIT_L, 7'h7f, 32'h08a3a49f, 5'h00, 40'h00ff375a, 1'b1);
        chk(40'(stall), 40'h0);
        chk(result.data, 40'h08ffb7df);
        chk(40'(result.dst), 40'h03);
        disp.op(ICX_UNIT_S, 7'h1b, 32'h08a3a49f, 5'h00, 40'h00ff375a, 1'b0);
        chk(result.data, 40'h08ffb7df);
        disp.op(ICX_UNIT_L, 7'h7e, 32'h0, 5'h14, 40'h0000003a41, 1'b0);
        chk(result.data, 40'h00fffffff5);
        disp.op(ICX_UNIT_S, 7'h1a, 32'h0, 5'h0f, 40'h0000000100, 1'b0);
        chk(result.data, 40'h000000010f);
        chk(40'(result.valid), 40'h1);
    endtask

    task automatic t_not_norm();
        disp.op(ICX_UNIT_L, 7'h00, 32'h0, 5'h00, 40'hff12345678, 1'b0);
        chk(result.data, 40'h00edcba987);
        disp.op(ICX_UNIT_L, 7'h63, 32'h0, 5'h00, 40'h0002a3469f, 1'b0);
        chk(result.data, 40'h5);
        disp.op(ICX_UNIT_L, 7'h63, 32'h0, 5'h00, 40'hfffffff25a, 1'b0);
        chk(result.data, 40'h13);
        disp.op(ICX_UNIT_L, 7'h60, 32'h0, 5'h00, 40'hffffffffff, 1'b0);
        chk(result.data, 40'h27);
        disp.op(ICX_UNIT_L, 7'h60, 32'h0, 5'h00, 40'h0080000000, 1'b0);
        chk(result.data, 40'h7);
        disp.op(ICX_UNIT_L, 7'h60, 32'h0, 5'h00, 40'h0000000001, 1'b0);
        chk(result.data, 40'h26);
        disp.quiet();
        @(negedge sys_clk);
    endtask

    // Branch cut ends the stall one cycle after it lands
    task automatic t_idle(input int len, input int cut);
        int last;
        last = (cut > 0) ? cut + 1 : ((len > 9) ? 9 : len);
        disp.idle(len);
        disp.quiet();
        chk(40'(idle_err), 40'(len > 9));
        for (int i = 1; i <= last; i++) begin
            chk(40'(stall), 40'(i < last));
            disp.brk(i == cut);
            @(negedge sys_clk);
        end
    endtask

    // An op held through the stall is only taken once it clears
    task automatic t_hold();
        disp.idle(4);
        disp.op(ICX_UNIT_L, 7'h7f, 32'h1, 5'h00, 40'h2, 1'b0);
        repeat (3) begin
            chk(40'(result.valid), 40'h0);
            @(negedge sys_clk);
        end
        chk(40'(result.valid), 40'h1);
        chk(result.data, 40'h3);
        disp.quiet();
        @(negedge sys_clk);
    endtask

    initial begin
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        chk(40'(stall), 40'h0);
        t_or();
        t_not_norm();
        t_idle(1, 0);
        t_idle(4, 0);
        t_idle(9, 0);
        t_idle(10, 0);
        t_idle(6, 2);
        t_hold();
        conclude();
    end

    // Run needs well under 200 cycles
    initial begin
        #200000;
        error_cnt++;
        conclude();
    end
endmodule
